// [bench/rail_command_bank_checker.sv]
// Port assertions for the rail command bank
`timescale 1ns/1ps
`default_nettype none
module rail_command_bank_checker
  import rail_bank_pkg::*;
(
  // Inputs watched
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_adc_tick,
  input wire logic [3:0] i_on_req,
  // Outputs watched
  input wire logic o_energy_clear,
  input wire logic [3:0] o_on,
  input wire logic o_alert_n_out,
  input wire logic o_alert_n_oe_n,
  input wire logic [3:0] o_dac_soft_req,
  input wire logic [3:0][31:0] o_gain_eff,
  input wire logic [3:0][31:0] o_tcorr
);
  localparam logic [31:0] GMIN = GAIN_MIN_Q16[31:0];
  localparam logic [31:0] GMAX = GAIN_MAX_Q16[31:0];
  localparam logic [31:0] TMIN = TCORR_MIN_Q16[31:0];
  localparam logic [31:0] TMAX = TCORR_MAX_Q16[31:0];
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence clear_pulse;
    o_energy_clear ##1 !o_energy_clear;
  endsequence
  clear_tick_a: assert property (o_energy_clear |-> $past(i_adc_tick)) else $error("clear off tick");
  clear_once_a: assert property (o_energy_clear |-> clear_pulse) else $error("clear too long");
  on_cause_a: assert property ($rose(o_on[0]) |-> $past(i_on_req[0])) else $error("on unasked");
  alert_cause_a: assert property ($fell(o_alert_n_oe_n) |-> $past(|i_on_req)) else $error("alert uncaused");
  alert_value_a: assert property (!o_alert_n_out) else $error("alert value high");
  soft_on_a: assert property ((o_dac_soft_req & ~o_on) == 4'h0) else $error("soft req off");
  gain_clamp_a: assert property ((|o_gain_eff[0]) |-> o_gain_eff[0] inside {[GMIN:GMAX]}) else $error("gain");
  tcorr_clamp_a: assert property ((|o_tcorr[0]) |-> o_tcorr[0] inside {[TMIN:TMAX]}) else $error("tcorr");
endmodule : rail_command_bank_checker
bind rail_command_bank rail_command_bank_checker checker_i (.i_clk, .i_rst, .i_adc_tick, .i_on_req,
  .o_energy_clear, .o_on, .o_alert_n_out, .o_alert_n_oe_n, .o_dac_soft_req, .o_gain_eff, .o_tcorr);
`default_nettype wire

// [bench/rail_command_bank_test.sv]
// Self-checking bench for the rail command bank
`timescale 1ns/1ps
`default_nettype none
module rail_command_bank_test;
  import rail_bank_pkg::*;
  logic i_clk, i_rst, i_adc_tick;
  logic [47:0] i_energy, i_energy_time;
  logic [3:0] i_on_req, i_rise_done, i_soft_done, i_ext_temp_valid, o_on, o_dac_connect, o_pgood, o_below_uv;
  logic [3:0][15:0] i_vout, i_ext_temp, i_self_heat, o_vout_target;
  logic [3:0][1:0] i_margin_sel;
  logic [3:0][9:0] i_soft_code, o_dac_code;
  logic [3:0][31:0] i_sense_dv, o_iout;
  logic [15:0] i_die_temp, rd;
  wire logic i_scl, sda_host, o_sda_oe_n, o_alert_n_oe_n, o_energy_clear;
  wire logic i_sda_in = sda_host & o_sda_oe_n;
  int model [4][SLOTS];
  int bad_count, total_checks, cycles, clears, p, s, v;
  smbus_host host (.i_sda(i_sda_in), .o_scl(i_scl), .o_sda(sda_host));
  rail_command_bank dut (.i_clk, .i_rst, .i_scl, .i_sda_in, .o_sda_out(), .o_sda_oe_n, .o_alert_n_out(),
    .o_alert_n_oe_n, .i_adc_tick, .i_energy, .i_energy_time, .o_energy_clear, .i_on_req, .i_rise_done,
    .i_vout, .i_margin_sel, .i_soft_done, .i_soft_code, .i_sense_dv, .i_ext_temp, .i_ext_temp_valid,
    .i_self_heat, .i_die_temp, .o_on, .o_pgood, .o_below_uv, .o_vout_target, .o_dac_code,
    .o_dac_connect, .o_dac_soft_req(), .o_gain_eff(), .o_tcorr(), .o_iout, .o_reverse_threshold());
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    clears += int'(o_energy_clear);
    if (cycles == 90000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s: %h not %h", $time, what, got, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic set_ch(input logic on, input logic [15:0] vo);
    @(posedge i_clk);
    i_on_req[0] <= on;
    i_rise_done[0] <= on;
    i_vout[0] <= vo;
    repeat (3) @(posedge i_clk);
  endtask : set_ch
  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    p = $urandom(49509);
    {i_adc_tick, i_on_req, i_rise_done, i_soft_done, i_margin_sel, i_vout, i_soft_code} = '0;
    {i_energy, i_energy_time, i_die_temp} = {$urandom, $urandom, $urandom, 16'h1900};
    i_ext_temp_valid = 4'h5;
    for (p = 0; p < 4; p++) begin
      i_sense_dv[p] = $urandom;
      i_ext_temp[p] = 16'($urandom_range(16'h3FFF));
      i_self_heat[p] = 16'($urandom_range(16'h03FF));
      for (s = 0; s < SLOTS; s++) model[p][s] = SLOT_RESET[s];
    end
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    for (s = 0; s < SLOTS; s++) begin
      host.read(SLOT_CMD[s], 2, rd);
      check(rd, SLOT_RESET[s], "reset");
    end
    host.xfer(CMD_OUTPUT_VOLTAGE_FORMAT, 1, 16'h00FF);
    host.read(CMD_OUTPUT_VOLTAGE_FORMAT, 1, rd);
    check(rd, 16'h0013, "format");
    repeat (4) begin
      p = $urandom_range(3);
      s = $urandom_range(SLOTS - 1);
      v = $urandom_range(16'hFFFF);
      if (s == SLOT_REVERSE_CURRENT) v = v | 32'h0400;
      host.xfer(CMD_PAGE, 1, 16'(p));
      host.xfer(SLOT_CMD[s], 2, v[15:0]);
      model[p][s] = v;
      host.xfer(CMD_PAGE, 1, 16'((p + 1) % 4));
      host.read(SLOT_CMD[s], 2, rd);
      check(rd, model[(p + 1) % 4][s][15:0], "page");
      host.xfer(CMD_PAGE, 1, 16'(p));
      host.read(SLOT_CMD[s], 2, rd);
      check(rd, v[15:0], "readback");
    end
    host.xfer(CMD_PAGE, 1, 16'h0000);
    host.xfer(SLOT_CMD[SLOT_SETPOINT], 2, 16'h3000);
    host.xfer(SLOT_CMD[SLOT_CEILING], 2, 16'h2800);
    model[0][SLOT_SETPOINT] = 32'h3000;
    model[0][SLOT_CEILING] = 32'h2800;
    for (v = 0; v < 4; v++) begin
      @(posedge i_clk);
      i_margin_sel <= {4{v[1:0]}};
      repeat (3) @(posedge i_clk);
      for (p = 0; p < 4; p++) begin
        s = (v == 1) ? SLOT_MARGIN_LOW : (v == 2) ? SLOT_MARGIN_HIGH : SLOT_SETPOINT;
        s = model[p][s] < model[p][SLOT_CEILING] ? model[p][s] : model[p][SLOT_CEILING];
        check(o_vout_target[p], s[15:0], "target");
      end
    end
    host.xfer(SLOT_CMD[SLOT_DISCHARGE], 2, 16'hC200);
    set_ch(1'b1, 16'hFFFF);
    check(o_on[0], 16'h0001, "no check");
    host.xfer(CMD_DIRECT_TRIM_CODE, 2, 16'h0155);
    host.read(CMD_DIRECT_TRIM_CODE, 2, rd);
    check(rd, 16'h0000, "trim mode 00");
    host.xfer(CMD_CHANNEL_CONFIG, 2, 16'h0020);
    host.xfer(CMD_DIRECT_TRIM_CODE, 2, 16'hFFFF);
    host.read(CMD_DIRECT_TRIM_CODE, 2, rd);
    check(rd, 16'h03FF, "trim");
    check({o_dac_connect[0], 5'h00, o_dac_code[0]}, 16'h83FF, "hard");
    set_ch(1'b0, 16'hFFFF);
    host.xfer(CMD_DIRECT_TRIM_CODE, 2, 16'h0001);
    host.read(CMD_DIRECT_TRIM_CODE, 2, rd);
    check(rd, 16'h03FF, "trim off");
    host.xfer(SLOT_CMD[SLOT_DISCHARGE], 2, 16'hBA00);
    set_ch(1'b1, 16'hFFFF);
    check({o_on[0], o_alert_n_oe_n, o_pgood[0], o_below_uv[0]}, 16'h0002, "held");
    set_ch(1'b1, 16'h0000);
    check(o_on[0], 16'h0001, "decayed");
    v = int'({model[0][SLOT_PGOOD_ASSERT] == 0, model[0][SLOT_UV_FAULT] != 0});
    check({o_pgood[0], o_below_uv[0]}, v[15:0], "pgood off");
    host.xfer(CMD_DISCHARGE_STATUS, 1, 16'h0001);
    check(o_alert_n_oe_n, 16'h0001, "alert clear");
    host.xfer(SLOT_CMD[SLOT_SENSE_GAIN], 2, 16'hBA00);
    host.xfer(SLOT_CMD[SLOT_TEMPCO], 2, 16'h0000);
    host.xfer(CMD_CHANNEL_CONFIG, 2, 16'h0030);
    check(o_dac_connect[0], 16'h0000, "soft wait");
    v = $urandom_range(10'h3FF);
    @(posedge i_clk);
    {i_soft_done[0], i_soft_code[0]} <= {1'b1, v[9:0]};
    host.read(CMD_DIRECT_TRIM_CODE, 2, rd);
    check(rd, v[15:0], "soft code");
    check(o_dac_connect[0], 16'h0001, "soft connect");
    host.xfer(CMD_WRITE_PROTECT, 1, 16'h0001);
    host.xfer(SLOT_CMD[SLOT_SETPOINT], 2, 16'h1000);
    host.read(SLOT_CMD[SLOT_SETPOINT], 2, rd);
    check(rd, 16'h3000, "protected");
    host.xfer(CMD_ENERGY_CLEAR, 0, 16'h0000);
    check(16'(clears), 16'h0000, "early clear");
    @(posedge i_clk);
    i_adc_tick <= 1'b1;
    @(posedge i_clk);
    i_adc_tick <= 1'b0;
    repeat (3) @(posedge i_clk);
    check(16'(clears), 16'h0001, "clear");
    repeat (50) @(posedge i_clk);
    check(o_iout[0][15:0], i_sense_dv[0][15:0], "iout low");
    check(o_iout[0][31:16], i_sense_dv[0][31:16], "iout high");
    check(16'(host.ok), 16'h0001, "acks");
    summarize();
  end
endmodule : rail_command_bank_test
`default_nettype wire

// [bench/smbus_host.sv]
// Serial link host model for register reads and writes
`timescale 1ns/1ps
`default_nettype none
module smbus_host #(
  parameter logic [6:0] ADDR = 7'h5C
) (
  // Link lines
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  logic ok = 1'b1;
  initial {o_scl, o_sda} = 2'b11;
  task automatic put(input logic b, output logic got);
    o_sda = b;
    #40 o_scl = 1'b1;
    #40 got = i_sda;
    #40 o_scl = 1'b0;
    #40;
  endtask : put
  task automatic start();
    o_sda = 1'b1;
    #40 o_scl = 1'b1;
    #40 o_sda = 1'b0;
    #40 o_scl = 1'b0;
    #40;
  endtask : start
  task automatic send(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i], a);
    put(1'b1, a);
    ok &= (a === 1'b0);
  endtask : send
  task automatic take(input logic last, output logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put(1'b1, d[i]);
    put(last, a);
  endtask : take
  task automatic stop();
    o_sda = 1'b0;
    #40 o_scl = 1'b1;
    #40 o_sda = 1'b1;
    #1000;
  endtask : stop
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [15:0] d);
    start();
    send({ADDR, 1'b0});
    send(cmd);
    if (n > 0) send(d[7:0]);
    if (n > 1) send(d[15:8]);
    stop();
  endtask : xfer
  task automatic read(input logic [7:0] cmd, input int n, output logic [15:0] d);
    d = 16'h0000;
    start();
    send({ADDR, 1'b0});
    send(cmd);
    start();
    send({ADDR, 1'b1});
    take(n == 1, d[7:0]);
    if (n > 1) take(1'b1, d[15:8]);
    stop();
  endtask : read
endmodule : smbus_host
`default_nettype wire

// [common/rail_bank_pkg.sv]
// Constants, register map and state types of the output rail command bank
package rail_bank_pkg;
  localparam int CHANNELS = 4;
  // Commands of the bank
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_WRITE_PROTECT = 8'h10;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_FORMAT = 8'h20;
  localparam logic [7:0] CMD_ENERGY_CLEAR = 8'hCC;
  localparam logic [7:0] CMD_DIRECT_TRIM_CODE = 8'hE0;
  localparam logic [7:0] CMD_CHANNEL_CONFIG = 8'hD0;
  localparam logic [7:0] CMD_CONFIG_ALL = 8'hD1;
  localparam logic [7:0] CMD_DISCHARGE_STATUS = 8'h80;
  localparam logic [7:0] CMD_ENERGY_BLOCK = 8'hC1;
  // Paged word registers, one slot each
  localparam int SLOTS = 16;
  localparam logic [7:0] SLOT_CMD [0:SLOTS-1] = '{
    8'h21, 8'h24, 8'h25, 8'h26, 8'h38, 8'h40, 8'h42, 8'h43,
    8'h44, 8'h46, 8'h4A, 8'h4B, 8'h5E, 8'h5F, 8'hE9, 8'hF6};
  localparam logic [15:0] SLOT_RESET [0:SLOTS-1] = '{
    16'h2000, 16'h8000, 16'h219A, 16'h1E66, 16'hBA00, 16'h2333, 16'h2266, 16'h1D9A,
    16'h1CCD, 16'hD280, 16'hCA80, 16'hB400, 16'h1EB8, 16'h1E14, 16'hC200, 16'h0000};
  localparam int SLOT_SETPOINT = 0;
  localparam int SLOT_CEILING = 1;
  localparam int SLOT_MARGIN_HIGH = 2;
  localparam int SLOT_MARGIN_LOW = 3;
  localparam int SLOT_SENSE_GAIN = 4;
  localparam int SLOT_UV_FAULT = 8;
  localparam int SLOT_REVERSE_CURRENT = 11;
  localparam int SLOT_PGOOD_ASSERT = 12;
  localparam int SLOT_PGOOD_DEASSERT = 13;
  localparam int SLOT_DISCHARGE = 14;
  localparam int SLOT_TEMPCO = 15;
  // Fixed fields and reset values
  localparam logic [2:0] FORMAT_LINEAR_MODE = 3'h0;
  localparam logic [4:0] FORMAT_EXPONENT = 5'h13;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_ALL_RESET = 16'h0000;
  localparam logic [7:0] WRITE_PROTECT_RESET = 8'h00;
  localparam logic [9:0] TRIM_RESET = 10'h000;
  localparam int DAC_MODE_LSB = 4;
  localparam logic [1:0] DAC_MODE_HARD = 2'h2;
  localparam logic [1:0] DAC_MODE_SOFT = 2'h3;
  localparam int PGOOD_OFF_USES_UV_POS = 0;
  localparam int DISCHARGE_FLAG_POS = 0;
  localparam logic [1:0] MARGIN_LOW_SEL = 2'h1;
  localparam logic [1:0] MARGIN_HIGH_SEL = 2'h2;
  localparam logic [7:0] ENERGY_BLOCK_LEN = 8'h0C;
  // Fixed point limits (Q16), reference and scale constants, divide step count
  localparam logic signed [63:0] ONE_Q16 = 64'sh10000;
  localparam logic signed [63:0] GAIN_MIN_Q16 = 64'sh28F;
  localparam logic signed [63:0] GAIN_MAX_Q16 = 64'sh3E80000;
  localparam logic signed [63:0] TCORR_MIN_Q16 = 64'sh4000;
  localparam logic signed [63:0] TCORR_MAX_Q16 = 64'sh40000;
  localparam logic signed [63:0] TEMP_REF_Q8 = 64'sh1900;
  localparam logic signed [63:0] PPM_TO_Q16 = 64'sh10C6F8;
  localparam logic signed [63:0] MILLI_PER_UNIT = 64'sh3E8;
  localparam logic [5:0] DIVIDE_STEPS = 6'h30;
  // Link byte phase and channel state
  typedef enum logic [1:0] {PH_ADDR = 2'b00, PH_CMD = 2'b01, PH_DATA = 2'b11, PH_IGNORE = 2'b10} phase_t;
  typedef enum logic [1:0] {CH_OFF = 2'b00, CH_HOLD = 2'b01, CH_ON = 2'b11} ch_state_t;
endpackage : rail_bank_pkg

// [core/rail_command_bank.sv]
// Paged command register bank with its serial link slave and channel logic
`timescale 1ns/1ps
`default_nettype none
module rail_command_bank
  import rail_bank_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h5C
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Serial link
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  output logic o_alert_n_out,
  output logic o_alert_n_oe_n,
  // Energy path
  input wire logic i_adc_tick,
  input wire logic [47:0] i_energy,
  input wire logic [47:0] i_energy_time,
  output logic o_energy_clear,
  // Channel inputs
  input wire logic [3:0] i_on_req,
  input wire logic [3:0] i_rise_done,
  input wire logic [3:0][15:0] i_vout,
  input wire logic [3:0][1:0] i_margin_sel,
  input wire logic [3:0] i_soft_done,
  input wire logic [3:0][9:0] i_soft_code,
  input wire logic [3:0][31:0] i_sense_dv,
  input wire logic [3:0][15:0] i_ext_temp,
  input wire logic [3:0] i_ext_temp_valid,
  input wire logic [3:0][15:0] i_self_heat,
  input wire logic [15:0] i_die_temp,
  // Channel outputs
  output logic [3:0] o_on,
  output logic [3:0] o_pgood,
  output logic [3:0] o_below_uv,
  output logic [3:0][15:0] o_vout_target,
  output logic [3:0][9:0] o_dac_code,
  output logic [3:0] o_dac_connect,
  output logic [3:0] o_dac_soft_req,
  output logic [3:0][31:0] o_gain_eff,
  output logic [3:0][31:0] o_tcorr,
  output logic [3:0][31:0] o_iout,
  output logic [3:0][31:0] o_reverse_threshold
);

  function automatic logic signed [63:0] l11_q16(input logic [15:0] v);
    logic signed [63:0] m;
    m = {{53{v[10]}}, v[10:0]};
    return m <<< {~v[15], v[14:11]};
  endfunction : l11_q16

  function automatic logic [4:0] slot_of(input logic [7:0] cmd);
    logic [4:0] r;
    r = 5'h10;
    for (int k = 0; k < SLOTS; k++) begin
      if (SLOT_CMD[k] == cmd) begin
        r = 5'(k);
      end
    end
    return r;
  endfunction : slot_of

  // Pin synchronisers and start/stop detection
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3F;
    end else begin
      scl_m <= i_scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= i_sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end
  logic start_p, stop_p;
  assign start_p = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_p = scl_s & scl_d & ~sda_d & sda_s;

  // Link engine held cleared from start or stop until the clock falls
  logic link_clr;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      link_clr <= 1'b1;
    end else if (start_p | stop_p) begin
      link_clr <= 1'b1;
    end else if (!scl_s) begin
      link_clr <= 1'b0;
    end
  end

  // Link domain bit engine
  logic [3:0] bit_cnt, rd_idx;
  logic [7:0] shreg;
  phase_t phase;
  logic is_read, ack_en;
  logic [127:0] rd_buf;
  logic [7:0] rd_byte;
  assign rd_byte = rd_buf[{rd_idx, 3'h0} +: 8];
  always_ff @(posedge i_scl or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      phase <= PH_ADDR;
      is_read <= 1'b0;
      ack_en <= 1'b0;
      rd_idx <= 4'h0;
    end else if (bit_cnt == 4'h8) begin
      bit_cnt <= 4'h0;
      if (phase == PH_DATA && is_read && i_sda_in) begin
        phase <= PH_IGNORE;
      end
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
      shreg <= {shreg[6:0], i_sda_in};
      if (bit_cnt == 4'h7) begin
        ack_en <= 1'b0;
        case (phase)
          PH_ADDR: begin
            if (shreg[6:0] == DEVICE_ADDRESS) begin
              ack_en <= 1'b1;
              is_read <= i_sda_in;
              phase <= i_sda_in ? PH_DATA : PH_CMD;
            end else begin
              phase <= PH_IGNORE;
            end
          end
          PH_CMD: begin
            ack_en <= 1'b1;
            phase <= PH_DATA;
          end
          PH_DATA: begin
            ack_en <= ~is_read;
            if (is_read) begin
              rd_idx <= rd_idx + 4'h1;
            end
          end
          default: begin
            ack_en <= 1'b0;
          end
        endcase
      end
    end
  end

  // Link domain command and write data, kept across repeated start
  logic [7:0] cmd_byte;
  logic [15:0] wdata;
  logic [2:0] wr_count;
  logic txn_write, addr_tog;
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      cmd_byte <= 8'h00;
      wdata <= 16'h0000;
      wr_count <= 3'h0;
      txn_write <= 1'b0;
      addr_tog <= 1'b0;
    end else if (bit_cnt == 4'h7) begin
      if (phase == PH_ADDR && shreg[6:0] == DEVICE_ADDRESS) begin
        txn_write <= ~i_sda_in;
        if (!i_sda_in) begin
          wr_count <= 3'h0;
          addr_tog <= ~addr_tog;
        end
      end else if (phase == PH_CMD) begin
        cmd_byte <= {shreg[6:0], i_sda_in};
        wr_count <= 3'h1;
      end else if (phase == PH_DATA && !is_read && wr_count != 3'h4) begin
        wr_count <= wr_count + 3'h1;
        if (wr_count == 3'h1) begin
          wdata[7:0] <= {shreg[6:0], i_sda_in};
        end else if (wr_count == 3'h2) begin
          wdata[15:8] <= {shreg[6:0], i_sda_in};
        end
      end
    end
  end

  // Data and acknowledge driven on the falling clock
  assign o_sda_out = 1'b0;
  always_ff @(negedge i_scl or posedge link_clr) begin
    if (link_clr) begin
      o_sda_oe_n <= 1'b1;
    end else if (bit_cnt == 4'h8) begin
      o_sda_oe_n <= ~ack_en;
    end else if (phase == PH_DATA && is_read) begin
      o_sda_oe_n <= rd_byte[3'h7 - bit_cnt[2:0]];
    end else begin
      o_sda_oe_n <= 1'b1;
    end
  end

  // Register storage
  logic [1:0] page;
  logic [7:0] write_protect;
  logic [15:0] config_all;
  logic [15:0] words [0:CHANNELS-1][0:SLOTS-1];
  logic [15:0] chan_cfg [0:CHANNELS-1];
  logic [9:0] trim [0:CHANNELS-1];
  logic [3:0] dis_flag;
  logic seen_tog, commit, allowed, clear_pend;
  logic [4:0] wslot;
  assign commit = stop_p & txn_write & (addr_tog != seen_tog);
  assign wslot = slot_of(cmd_byte);
  assign allowed = (write_protect == WRITE_PROTECT_RESET) || cmd_byte == CMD_PAGE ||
                   cmd_byte == CMD_WRITE_PROTECT || cmd_byte == CMD_ENERGY_CLEAR;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      page <= 2'h0;
      write_protect <= WRITE_PROTECT_RESET;
      config_all <= CONFIG_ALL_RESET;
      for (int c = 0; c < CHANNELS; c++) begin
        chan_cfg[c] <= CONFIG_RESET;
        for (int k = 0; k < SLOTS; k++) begin
          words[c][k] <= SLOT_RESET[k];
        end
      end
    end else if (commit) begin
      if (allowed && wr_count == 3'h2 && cmd_byte == CMD_PAGE && wdata[7:2] == 6'h00) begin
        page <= wdata[1:0];
      end
      if (wr_count == 3'h2 && cmd_byte == CMD_WRITE_PROTECT) begin
        write_protect <= wdata[7:0];
      end
      if (allowed && wr_count == 3'h3) begin
        if (!wslot[4]) begin
          words[page][wslot[3:0]] <= wdata;
        end
        if (cmd_byte == CMD_CHANNEL_CONFIG) begin
          chan_cfg[page] <= wdata;
        end
        if (cmd_byte == CMD_CONFIG_ALL) begin
          config_all <= wdata;
        end
      end
    end
  end

  // Every stop marks the last address phase as seen, reads included
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      seen_tog <= 1'b0;
    end else if (stop_p) begin
      seen_tog <= addr_tog;
    end
  end

  // Clear held pending until the next conversion boundary
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      clear_pend <= 1'b0;
      o_energy_clear <= 1'b0;
    end else begin
      o_energy_clear <= clear_pend & i_adc_tick;
      if (commit && allowed && wr_count == 3'h1 && cmd_byte == CMD_ENERGY_CLEAR) begin
        clear_pend <= 1'b1;
      end else if (i_adc_tick) begin
        clear_pend <= 1'b0;
      end
    end
  end

  // Read buffer captured at each start, frozen for the read
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_buf <= 128'h0;
    end else if (start_p) begin
      rd_buf <= 128'h0;
      if (!wslot[4]) begin
        rd_buf[15:0] <= words[page][wslot[3:0]];
      end
      case (cmd_byte)
        CMD_OUTPUT_VOLTAGE_FORMAT: rd_buf[7:0] <= {FORMAT_LINEAR_MODE, FORMAT_EXPONENT};
        CMD_PAGE: rd_buf[7:0] <= {6'h00, page};
        CMD_WRITE_PROTECT: rd_buf[7:0] <= write_protect;
        CMD_DIRECT_TRIM_CODE: rd_buf[15:0] <= {6'h00, trim[page]};
        CMD_CHANNEL_CONFIG: rd_buf[15:0] <= chan_cfg[page];
        CMD_CONFIG_ALL: rd_buf[15:0] <= config_all;
        CMD_DISCHARGE_STATUS: rd_buf[7:0] <= 8'(dis_flag[page]) << DISCHARGE_FLAG_POS;
        CMD_ENERGY_BLOCK: rd_buf[103:0] <= {i_energy_time, i_energy, ENERGY_BLOCK_LEN};
        default: begin
        end
      endcase
    end
  end

  assign o_alert_n_out = 1'b0;
  assign o_alert_n_oe_n = ~(|dis_flag);

  // Per channel logic
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
    ch_state_t state;
    logic signed [63:0] thr, coef, gain_q, gain_c, uc_q, tc, dtemp, corr, corr_c, scale;
    logic [15:0] vout, sel;
    logic [1:0] mode;
    logic undecayed, check_off, host_trim, host_flag_clr, soft_done;
    logic [47:0] dd;
    logic [32:0] rem, trial;
    logic [31:0] den, dv;
    logic [5:0] div_cnt;
    logic div_neg;

    assign vout = i_vout[ch];
    assign mode = chan_cfg[ch][DAC_MODE_LSB +: 2];
    assign coef = l11_q16(words[ch][SLOT_DISCHARGE]);
    assign thr = coef * $signed({48'h0, words[ch][SLOT_SETPOINT]});
    assign check_off = coef > ONE_Q16;
    assign undecayed = $signed({32'h0, vout, 16'h0}) >= thr;
    assign host_trim = commit && allowed && wr_count == 3'h3 && cmd_byte == CMD_DIRECT_TRIM_CODE &&
                       page == ch;
    assign host_flag_clr = commit && allowed && wr_count == 3'h2 && cmd_byte == CMD_DISCHARGE_STATUS &&
                           page == ch && wdata[DISCHARGE_FLAG_POS];

    // On/off sequencing with discharge check
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        state <= CH_OFF;
      end else begin
        case (state)
          CH_OFF: if (i_on_req[ch]) begin
            state <= (undecayed && !check_off) ? CH_HOLD : CH_ON;
          end
          CH_HOLD: if (!i_on_req[ch]) begin
            state <= CH_OFF;
          end else if (!undecayed || check_off) begin
            state <= CH_ON;
          end
          CH_ON: if (!i_on_req[ch]) begin
            state <= CH_OFF;
          end
          default: state <= CH_OFF;
        endcase
      end
    end
    assign o_on[ch] = state == CH_ON;

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        dis_flag[ch] <= 1'b0;
      end else if (state == CH_OFF && i_on_req[ch] && undecayed && !check_off) begin
        dis_flag[ch] <= 1'b1;
      end else if (host_flag_clr) begin
        dis_flag[ch] <= 1'b0;
      end
    end

    // Trim code, hard and soft connect
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        trim[ch] <= TRIM_RESET;
        soft_done <= 1'b0;
      end else begin
        if (state == CH_ON && mode == DAC_MODE_SOFT && !soft_done && i_soft_done[ch]) begin
          trim[ch] <= i_soft_code[ch];
          soft_done <= 1'b1;
        end else if (host_trim && state == CH_ON && i_rise_done[ch] && mode[1]) begin
          trim[ch] <= wdata[9:0];
        end
        if (state != CH_ON || mode != DAC_MODE_SOFT) begin
          soft_done <= 1'b0;
        end
      end
    end
    assign o_dac_soft_req[ch] = state == CH_ON && mode == DAC_MODE_SOFT && !soft_done;
    assign o_dac_connect[ch] = state == CH_ON && (mode == DAC_MODE_HARD || (mode == DAC_MODE_SOFT && soft_done));

    // Target, power good, undervoltage
    always_comb begin
      sel = words[ch][SLOT_SETPOINT];
      if (i_margin_sel[ch] == MARGIN_LOW_SEL) begin
        sel = words[ch][SLOT_MARGIN_LOW];
      end else if (i_margin_sel[ch] == MARGIN_HIGH_SEL) begin
        sel = words[ch][SLOT_MARGIN_HIGH];
      end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        o_vout_target[ch] <= SLOT_RESET[SLOT_SETPOINT];
        o_pgood[ch] <= 1'b0;
        o_below_uv[ch] <= 1'b0;
        o_dac_code[ch] <= TRIM_RESET;
      end else begin
        o_vout_target[ch] <= (sel > words[ch][SLOT_CEILING]) ? words[ch][SLOT_CEILING] : sel;
        o_below_uv[ch] <= vout < words[ch][SLOT_UV_FAULT];
        o_dac_code[ch] <= trim[ch];
        if (vout >= words[ch][SLOT_PGOOD_ASSERT]) begin
          o_pgood[ch] <= 1'b1;
        end else if (config_all[PGOOD_OFF_USES_UV_POS] ? vout < words[ch][SLOT_UV_FAULT] :
                     vout <= words[ch][SLOT_PGOOD_DEASSERT]) begin
          o_pgood[ch] <= 1'b0;
        end
      end
    end

    // Gain clamp and temperature correction
    assign gain_q = l11_q16(words[ch][SLOT_SENSE_GAIN]);
    assign gain_c = gain_q < GAIN_MIN_Q16 ? GAIN_MIN_Q16 : gain_q > GAIN_MAX_Q16 ? GAIN_MAX_Q16 : gain_q;
    assign tc = {{48{words[ch][SLOT_TEMPCO][15]}}, words[ch][SLOT_TEMPCO]};
    assign dtemp = {{48{i_self_heat[ch][15]}}, i_self_heat[ch]} - TEMP_REF_Q8 +
                   (i_ext_temp_valid[ch] ? {{48{i_ext_temp[ch][15]}}, i_ext_temp[ch]} :
                    {{48{i_die_temp[15]}}, i_die_temp});
    assign corr = ONE_Q16 + ((tc * dtemp * PPM_TO_Q16) >>> 32);
    assign corr_c = corr < TCORR_MIN_Q16 ? TCORR_MIN_Q16 : corr > TCORR_MAX_Q16 ? TCORR_MAX_Q16 : corr;
    assign scale = (gain_c * corr_c) >>> 16;
    assign uc_q = l11_q16(words[ch][SLOT_REVERSE_CURRENT]);
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        o_gain_eff[ch] <= 32'h0;
        o_tcorr[ch] <= 32'h0;
        o_reverse_threshold[ch] <= 32'h0;
      end else begin
        o_gain_eff[ch] <= gain_c[31:0];
        o_tcorr[ch] <= corr_c[31:0];
        o_reverse_threshold[ch] <= 32'((uc_q * MILLI_PER_UNIT * scale) >>> 32);
      end
    end

    // Current by serial division at each ADC update
    assign dv = i_sense_dv[ch][31] ? 32'h0 - i_sense_dv[ch] : i_sense_dv[ch];
    assign trial = {rem[31:0], dd[47]} - {1'b0, den};
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        dd <= 48'h0;
        rem <= 33'h0;
        den <= 32'h1;
        div_cnt <= 6'h0;
        div_neg <= 1'b0;
        o_iout[ch] <= 32'h0;
      end else if (div_cnt == 6'h0) begin
        if (i_adc_tick) begin
          dd <= {dv, 16'h0};
          rem <= 33'h0;
          den <= (scale[31:0] == 32'h0) ? 32'h1 : scale[31:0];
          div_neg <= i_sense_dv[ch][31];
          div_cnt <= DIVIDE_STEPS;
        end
      end else begin
        rem <= trial[32] ? {rem[31:0], dd[47]} : trial;
        dd <= {dd[46:0], ~trial[32]};
        div_cnt <= div_cnt - 6'h1;
        if (div_cnt == 6'h1) begin
          o_iout[ch] <= div_neg ? 32'h0 - {dd[30:0], ~trial[32]} : {dd[30:0], ~trial[32]};
        end
      end
    end
  end

endmodule : rail_command_bank
`default_nettype wire
